// file: bench/charger_event_flag_latches_tb.sv
// self-checking bench for the charger event flag latch block
`timescale 1ns/1ps
`default_nettype none
module charger_event_flag_latches_tb;
  logic        clk_in    = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        rd_en     = 1'b0;
  logic        wr_en     = 1'b0;
  logic        one       = 1'b0;
  logic [7:0]  addr      = 8'h00;
  logic [7:0]  wdat      = 8'h00;
  logic [7:0]  npul      = 8'h00;
  logic [7:0]  rdat;
  logic        rval;
  logic        int_n;
  logic [19:0] c         = 20'h00000;
  logic [1:0]  cs        = 2'h0;
  logic [2:0]  src       = 3'h0;
  logic [2:0]  tz        = 3'h0;
  int          fails     = 0;
  int          samples_checked = 0;
  // flag bit of each condition, same order as the condition vector
  int bt[20] = '{6, 5, 4, 3, 3, 3, 2, 2, 1, 0, 7, 7, 6, 6, 5, 5, 4, 4, 4, 3};

  always #10 clk_in = ~clk_in;

  // count cycles with the interrupt line low, one per event when unmasked
  always @(posedge clk_in) begin
    if (int_n === 1'b0) npul <= npul + 8'h01;
  end

  cefl_flag_latches cefl_flag_latches_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .rd_en_in(rd_en),
    .wr_en_in(wr_en), .addr_in(addr), .wr_data_in(wdat),
    .rd_data_out(rdat), .rd_valid_out(rval), .int_n_out(int_n),
    .oneshot_mode_in(one), .conv_done_in(c[0]),
    .die_thermal_regulation_in(c[1]), .min_system_regulation_in(c[2]),
    .input_current_regulation_in(c[3]), .current_limit_pin_in(c[4]),
    .boost_current_regulation_in(c[5]),
    .input_voltage_regulation_in(c[6]),
    .boost_voltage_regulation_in(c[7]), .charge_timer_expired_in(c[8]),
    .host_watchdog_expired_in(c[9]), .input_overvoltage_in(c[10]),
    .input_sleep_in(c[11]), .battery_overcurrent_in(c[12]),
    .battery_overvoltage_in(c[13]), .system_overvoltage_in(c[14]),
    .system_short_in(c[15]), .boost_reverse_current_in(c[16]),
    .intermediate_node_uv_in(c[17]), .intermediate_node_ov_in(c[18]),
    .thermal_shutdown_in(c[19]), .charge_status_in(cs),
    .input_status_in(src), .temperature_zone_code_in(tz));

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one read strobe; data is taken the cycle after the strobe edge
  task automatic rdc(input string nm, input logic [7:0] a, exp);
    @(posedge clk_in);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd_en <= 1'b0;
    #1 chk(nm, rdat, exp);
    chk("rd_valid", {7'h00, rval}, 8'h01);
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_in);
    wr_en <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask

  // long enough for the input filter and the flag to land
  task automatic w8;
    repeat (8) @(posedge clk_in);
  endtask

  task automatic t_reset;
    rdc("flags_a", 8'h20, 8'h00);
    rdc("flags_b", 8'h21, 8'h00);
    rdc("flags_f", 8'h22, 8'h00);
    rdc("mask_a", 8'h23, 8'h00);
    wr(8'h22, 8'hFF);
    rdc("flags_f_ro", 8'h22, 8'h00);
  endtask

  task automatic t_conds;
    logic [7:0] a;
    logic [7:0] p;
    @(posedge clk_in) c[0] <= 1'b1;
    w8;
    rdc("oneshot_off", 8'h20, 8'h00);
    @(posedge clk_in) c[0] <= 1'b0;
    one <= 1'b1;
    w8;
    for (int i = 0; i < 20; i++) begin
      a = i < 10 ? 8'h20 : 8'h22;
      p = npul;
      @(posedge clk_in) c[i] <= 1'b1;
      w8;
      rdc("flag_set", a, 8'h01 << bt[i]);
      chk("int_pulses", npul - p, 8'h01);
      rdc("flag_clear", a, 8'h00);
      @(posedge clk_in) c[i] <= 1'b0;
      w8;
      rdc("fall_edge", a, i == 2 ? 8'h10 : 8'h00);
    end
  endtask

  // an event landing on the clearing read must survive that read
  task automatic t_coincide;
    @(posedge clk_in) c[1] <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd_en <= 1'b1;
    addr  <= 8'h20;
    @(posedge clk_in);
    rd_en <= 1'b0;
    #1 chk("read_before_set", rdat, 8'h00);
    rdc("set_kept", 8'h20, 8'h20);
    @(posedge clk_in) c[1] <= 1'b0;
    w8;
  endtask

  task automatic t_status;
    @(posedge clk_in) cs <= 2'h2;
    w8;
    rdc("charge_phase", 8'h21, 8'h08);
    @(posedge clk_in) src <= 3'h5;
    w8;
    rdc("input_source", 8'h21, 8'h01);
    // walk every zone code, each step must flag a change
    for (int k = 1; k < 8; k++) begin
      @(posedge clk_in) tz <= tz + 3'h1;
      w8;
      rdc("temp_zone", 8'h22, 8'h01);
    end
  endtask

  task automatic t_mask;
    logic [7:0] p;
    wr(8'h23, 8'hFF);
    rdc("mask_a", 8'h23, 8'hFF);
    wr(8'h24, 8'hFF);
    rdc("mask_b", 8'h24, 8'h09);
    wr(8'h25, 8'hFF);
    rdc("mask_f", 8'h25, 8'hF9);
    p = npul;
    @(posedge clk_in) c[9] <= 1'b1;
    w8;
    rdc("masked_flag", 8'h20, 8'h01);
    chk("masked_pulses", npul - p, 8'h00);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // cut a hang well beyond the expected run of under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk_in);
    fails++;
    give_verdict;
  end

  initial begin
    repeat (12) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_reset;
    t_conds;
    t_coincide;
    t_status;
    t_mask;
    give_verdict;
  end
endmodule
`default_nettype wire

// file: hw/cefl_cond_if.sv
// carrier for sampled condition levels and their edge pulses
`timescale 1ns/1ps
`default_nettype none
interface cefl_cond_if #(
  parameter int W = cefl_pkg::COND_W
);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  modport src (output level, output rise, output fall);
  modport snk (input level, input rise, input fall);
endinterface
`default_nettype wire

// file: hw/cefl_cond_sync.sv
// three-stage synchroniser and edge detector for the condition signals
`timescale 1ns/1ps
`default_nettype none
module cefl_cond_sync #(
  parameter int W = cefl_pkg::COND_W
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  // raw conditions from the analog side
  input  wire logic [W-1:0] raw_in,
  // filtered levels and edges
  cefl_cond_if.src          cond
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] held_level;
  logic [W-1:0] rise_pulse;
  logic [W-1:0] fall_pulse;
  logic [W-1:0] next_s1;
  logic [W-1:0] next_s2;
  logic [W-1:0] next_s3;
  logic [W-1:0] next_level;
  logic [W-1:0] next_rise;
  logic [W-1:0] next_fall;

  // level moves only where stages two and three agree; one-cycle pulses
  always_comb begin
    next_s1    = raw_in;
    next_s2    = s1;
    next_s3    = s2;
    next_level = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & held_level);
    next_rise  = next_level & ~held_level;
    next_fall  = ~next_level & held_level;
  end

  // register stage only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1         <= '0;
      s2         <= '0;
      s3         <= '0;
      held_level <= '0;
      rise_pulse <= '0;
      fall_pulse <= '0;
    end else begin
      s1         <= next_s1;
      s2         <= next_s2;
      s3         <= next_s3;
      held_level <= next_level;
      rise_pulse <= next_rise;
      fall_pulse <= next_fall;
    end
  end

  assign cond.level = held_level;
  assign cond.rise  = rise_pulse;
  assign cond.fall  = fall_pulse;

  a_sync_agree: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    ((held_level ^ $past(held_level)) & ($past(s2) ^ $past(s3))) == '0)
    else $error("level moved while sync stages disagreed");

  a_pulse_single: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    ((rise_pulse & $past(rise_pulse)) | (fall_pulse & $past(fall_pulse)))
      == '0)
    else $error("edge pulse lasted more than one cycle");

endmodule
`default_nettype wire

// file: hw/cefl_flag_latches.sv
// charger event flag latches with mask registers and interrupt pulse
`timescale 1ns/1ps
`default_nettype none
module cefl_flag_latches (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  // register port
  input  wire logic       rd_en_in,
  input  wire logic       wr_en_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  output logic      [7:0] rd_data_out,
  output logic            rd_valid_out,
  // interrupt pulse, low for one cycle
  output logic            int_n_out,
  // conversion control, same clock
  input  wire logic       oneshot_mode_in,
  // regulation conditions
  input  wire logic       conv_done_in,
  input  wire logic       die_thermal_regulation_in,
  input  wire logic       min_system_regulation_in,
  input  wire logic       input_current_regulation_in,
  input  wire logic       current_limit_pin_in,
  input  wire logic       boost_current_regulation_in,
  input  wire logic       input_voltage_regulation_in,
  input  wire logic       boost_voltage_regulation_in,
  input  wire logic       charge_timer_expired_in,
  input  wire logic       host_watchdog_expired_in,
  // fault conditions
  input  wire logic       input_overvoltage_in,
  input  wire logic       input_sleep_in,
  input  wire logic       battery_overcurrent_in,
  input  wire logic       battery_overvoltage_in,
  input  wire logic       system_overvoltage_in,
  input  wire logic       system_short_in,
  input  wire logic       boost_reverse_current_in,
  input  wire logic       intermediate_node_uv_in,
  input  wire logic       intermediate_node_ov_in,
  input  wire logic       thermal_shutdown_in,
  // status fields
  input  wire logic [1:0] charge_status_in,
  input  wire logic [2:0] input_status_in,
  input  wire logic [2:0] temperature_zone_code_in
);

  logic [cefl_pkg::COND_W-1:0] raw;
  logic [7:0]                  flags_a;
  logic [7:0]                  flags_b;
  logic [7:0]                  flags_f;
  logic [7:0]                  mask_a;
  logic [7:0]                  mask_b;
  logic [7:0]                  mask_f;
  logic [7:0]                  set_a;
  logic [7:0]                  set_b;
  logic [7:0]                  set_f;
  logic [7:0]                  clr_a;
  logic [7:0]                  clr_b;
  logic [7:0]                  clr_f;
  logic [7:0]                  next_flags_a;
  logic [7:0]                  next_flags_b;
  logic [7:0]                  next_flags_f;
  logic [7:0]                  next_mask_a;
  logic [7:0]                  next_mask_b;
  logic [7:0]                  next_mask_f;
  logic [7:0]                  next_rd_data;
  logic                        next_rd_valid;
  logic                        next_int_n;
  logic [23:0]                 set_all;
  logic [23:0]                 mask_all;
  cefl_pkg::cefl_tzone_t       zone;

  cefl_cond_if #(.W(cefl_pkg::COND_W)) cond ();

  // flag update: hardware set wins over the read clear
  function automatic logic [7:0] latch_flags(
    input logic [7:0] flag,
    input logic [7:0] set,
    input logic [7:0] clr,
    input logic [7:0] used
  );
    return ((flag & ~clr) | set) & used;
  endfunction

  // any change of a multi-bit status field
  function automatic logic field_changed(input logic [2:0] r,
                                         input logic [2:0] f);
    return |(r | f);
  endfunction

  // gather the asynchronous condition pins into one vector
  always_comb begin
    raw = '0;
    raw[cefl_pkg::C_CONV_DONE]  = conv_done_in;
    raw[cefl_pkg::C_THERM_REG]  = die_thermal_regulation_in;
    raw[cefl_pkg::C_MIN_SYS]    = min_system_regulation_in;
    raw[cefl_pkg::C_IN_CUR]     = input_current_regulation_in;
    raw[cefl_pkg::C_LIM_PIN]    = current_limit_pin_in;
    raw[cefl_pkg::C_BOOST_CUR]  = boost_current_regulation_in;
    raw[cefl_pkg::C_IN_VOLT]    = input_voltage_regulation_in;
    raw[cefl_pkg::C_BOOST_VOLT] = boost_voltage_regulation_in;
    raw[cefl_pkg::C_TIMER]      = charge_timer_expired_in;
    raw[cefl_pkg::C_WDOG]       = host_watchdog_expired_in;
    raw[cefl_pkg::C_IN_OVP]     = input_overvoltage_in;
    raw[cefl_pkg::C_IN_SLEEP]   = input_sleep_in;
    raw[cefl_pkg::C_BAT_OCP]    = battery_overcurrent_in;
    raw[cefl_pkg::C_BAT_OVP]    = battery_overvoltage_in;
    raw[cefl_pkg::C_SYS_OVP]    = system_overvoltage_in;
    raw[cefl_pkg::C_SYS_SHORT]  = system_short_in;
    raw[cefl_pkg::C_BOOST_REV]  = boost_reverse_current_in;
    raw[cefl_pkg::C_NODE_UV]    = intermediate_node_uv_in;
    raw[cefl_pkg::C_NODE_OV]    = intermediate_node_ov_in;
    raw[cefl_pkg::C_TSHUT]      = thermal_shutdown_in;
    raw[cefl_pkg::C_CHG_LSB +: cefl_pkg::CHG_W] = charge_status_in;
    raw[cefl_pkg::C_SRC_LSB +: cefl_pkg::SRC_W] = input_status_in;
    raw[cefl_pkg::C_TZ_LSB +: cefl_pkg::TZ_W]   = temperature_zone_code_in;
  end

  // analog conditions are asynchronous, so every bit is filtered first
  cefl_cond_sync #(.W(cefl_pkg::COND_W)) u_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .raw_in    (raw),
    .cond      (cond)
  );

  // filtered zone code, kept as a typed value for readability
  assign zone = cefl_pkg::cefl_tzone_t'(
    cond.level[cefl_pkg::C_TZ_LSB +: cefl_pkg::TZ_W]);

  // set pulses from the edges of the filtered conditions
  always_comb begin
    set_a = '0;
    set_b = '0;
    set_f = '0;
    set_a[cefl_pkg::BIT_CONV_DONE] = cond.rise[cefl_pkg::C_CONV_DONE]
                                     & oneshot_mode_in;
    set_a[cefl_pkg::BIT_THERM_REG] = cond.rise[cefl_pkg::C_THERM_REG];
    set_a[cefl_pkg::BIT_MIN_SYS]   = cond.rise[cefl_pkg::C_MIN_SYS]
                                     | cond.fall[cefl_pkg::C_MIN_SYS];
    set_a[cefl_pkg::BIT_IN_CUR]    = cond.rise[cefl_pkg::C_IN_CUR]
                                     | cond.rise[cefl_pkg::C_LIM_PIN]
                                     | cond.rise[cefl_pkg::C_BOOST_CUR];
    set_a[cefl_pkg::BIT_IN_VOLT]   = cond.rise[cefl_pkg::C_IN_VOLT]
                                     | cond.rise[cefl_pkg::C_BOOST_VOLT];
    set_a[cefl_pkg::BIT_TIMER]     = cond.rise[cefl_pkg::C_TIMER];
    set_a[cefl_pkg::BIT_WDOG]      = cond.rise[cefl_pkg::C_WDOG];
    set_b[cefl_pkg::BIT_CHG_PHASE] = field_changed(
      {1'b0, cond.rise[cefl_pkg::C_CHG_LSB +: cefl_pkg::CHG_W]},
      {1'b0, cond.fall[cefl_pkg::C_CHG_LSB +: cefl_pkg::CHG_W]});
    set_b[cefl_pkg::BIT_IN_SRC]    = field_changed(
      cond.rise[cefl_pkg::C_SRC_LSB +: cefl_pkg::SRC_W],
      cond.fall[cefl_pkg::C_SRC_LSB +: cefl_pkg::SRC_W]);
    set_f[cefl_pkg::BIT_IN_FAULT]  = cond.rise[cefl_pkg::C_IN_OVP]
                                     | cond.rise[cefl_pkg::C_IN_SLEEP];
    set_f[cefl_pkg::BIT_BAT_FAULT] = cond.rise[cefl_pkg::C_BAT_OCP]
                                     | cond.rise[cefl_pkg::C_BAT_OVP];
    set_f[cefl_pkg::BIT_SYS_FAULT] = cond.rise[cefl_pkg::C_SYS_OVP]
                                     | cond.rise[cefl_pkg::C_SYS_SHORT];
    set_f[cefl_pkg::BIT_BOOST_FAULT] = cond.rise[cefl_pkg::C_BOOST_REV]
                                     | cond.rise[cefl_pkg::C_NODE_UV]
                                     | cond.rise[cefl_pkg::C_NODE_OV];
    set_f[cefl_pkg::BIT_TSHUT]     = cond.rise[cefl_pkg::C_TSHUT];
    set_f[cefl_pkg::BIT_TZONE]     = field_changed(
      cond.rise[cefl_pkg::C_TZ_LSB +: cefl_pkg::TZ_W],
      cond.fall[cefl_pkg::C_TZ_LSB +: cefl_pkg::TZ_W]);
  end

  assign set_all  = {set_f, set_b, set_a};
  assign mask_all = {mask_f, mask_b, mask_a};

  // next state of flags, masks, read data and interrupt
  always_comb begin
    clr_a = (rd_en_in && addr_in == cefl_pkg::ADDR_FLAGS_A) ? 8'hFF : 8'h00;
    clr_b = (rd_en_in && addr_in == cefl_pkg::ADDR_FLAGS_B) ? 8'hFF : 8'h00;
    clr_f = (rd_en_in && addr_in == cefl_pkg::ADDR_FLAGS_F) ? 8'hFF : 8'h00;
    next_flags_a = latch_flags(flags_a, set_a, clr_a,
                               cefl_pkg::FLAGS_A_USED);
    next_flags_b = latch_flags(flags_b, set_b, clr_b,
                               cefl_pkg::FLAGS_B_USED);
    next_flags_f = latch_flags(flags_f, set_f, clr_f,
                               cefl_pkg::FLAGS_F_USED);
    next_mask_a = mask_a;
    next_mask_b = mask_b;
    next_mask_f = mask_f;
    // only the mask offsets take writes; flag offsets ignore them
    if (wr_en_in) begin
      case (addr_in)
        cefl_pkg::ADDR_MASK_A: next_mask_a = wr_data_in & cefl_pkg::MASK_A_USED;
        cefl_pkg::ADDR_MASK_B: next_mask_b = wr_data_in & cefl_pkg::MASK_B_USED;
        cefl_pkg::ADDR_MASK_F: next_mask_f = wr_data_in & cefl_pkg::MASK_F_USED;
        default: next_mask_a = mask_a;
      endcase
    end
    // read returns the value held before this cycle's clear
    case (addr_in)
      cefl_pkg::ADDR_FLAGS_A: next_rd_data = flags_a;
      cefl_pkg::ADDR_FLAGS_B: next_rd_data = flags_b;
      cefl_pkg::ADDR_FLAGS_F: next_rd_data = flags_f;
      cefl_pkg::ADDR_MASK_A:  next_rd_data = mask_a;
      cefl_pkg::ADDR_MASK_B:  next_rd_data = mask_b;
      cefl_pkg::ADDR_MASK_F:  next_rd_data = mask_f;
      default:                next_rd_data = 8'h00;
    endcase
    if (!rd_en_in) begin
      next_rd_data = rd_data_out;
    end
    next_rd_valid = rd_en_in;
    next_int_n = ~|(set_all & ~mask_all);
  end

  // register stage only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flags_a      <= cefl_pkg::FLAG_RESET;
      flags_b      <= cefl_pkg::FLAG_RESET;
      flags_f      <= cefl_pkg::FLAG_RESET;
      mask_a       <= cefl_pkg::MASK_RESET;
      mask_b       <= cefl_pkg::MASK_RESET;
      mask_f       <= cefl_pkg::MASK_RESET;
      rd_data_out  <= 8'h00;
      rd_valid_out <= 1'b0;
      int_n_out    <= 1'b1;
    end else begin
      flags_a      <= next_flags_a;
      flags_b      <= next_flags_b;
      flags_f      <= next_flags_f;
      mask_a       <= next_mask_a;
      mask_b       <= next_mask_b;
      mask_f       <= next_mask_f;
      rd_data_out  <= next_rd_data;
      rd_valid_out <= next_rd_valid;
      int_n_out    <= next_int_n;
    end
  end

  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  a_conv_done_set: assert property (
    cond.rise[cefl_pkg::C_CONV_DONE] && oneshot_mode_in |=> flags_a[6])
    else $error("conversion flag missed in one-shot mode");
  a_conv_mode_gate: assert property (
    !flags_a[6] && !oneshot_mode_in |=> !flags_a[6])
    else $error("conversion flag set outside one-shot mode");
  a_therm_reg_set: assert property (
    cond.rise[cefl_pkg::C_THERM_REG] |=> flags_a[5])
    else $error("thermal regulation flag missed");
  a_minsys_edges: assert property (
    $changed(min_system_regulation_in) ##1
      $stable(min_system_regulation_in) [*2] |-> ##3 flags_a[4])
    else $error("min system flag missed an edge");
  a_in_cur_set: assert property (
    cond.rise[cefl_pkg::C_LIM_PIN] || cond.rise[cefl_pkg::C_BOOST_CUR]
    |=> flags_a[3])
    else $error("input current flag missed");
  a_in_volt_set: assert property (
    cond.rise[cefl_pkg::C_BOOST_VOLT] |=> flags_a[2])
    else $error("input voltage flag missed");
  a_timer_set: assert property (
    cond.rise[cefl_pkg::C_TIMER] |=> flags_a[1])
    else $error("safety timer flag missed");
  a_wdog_set: assert property (
    cond.rise[cefl_pkg::C_WDOG] |=> flags_a[0])
    else $error("watchdog flag missed");
  a_chg_change: assert property (
    $changed(cond.level[cefl_pkg::C_CHG_LSB +: cefl_pkg::CHG_W])
    |=> flags_b[3])
    else $error("charge phase change not flagged");
  a_src_change: assert property (
    $changed(cond.level[cefl_pkg::C_SRC_LSB +: cefl_pkg::SRC_W])
    |=> flags_b[0])
    else $error("input source change not flagged");
  a_fault_sets: assert property (
    cond.rise[cefl_pkg::C_IN_SLEEP] || cond.rise[cefl_pkg::C_BAT_OVP]
    || cond.rise[cefl_pkg::C_SYS_SHORT] || cond.rise[cefl_pkg::C_NODE_OV]
    || cond.rise[cefl_pkg::C_BOOST_REV] || cond.rise[cefl_pkg::C_TSHUT]
    |=> (flags_f[7] || !$past(cond.rise[cefl_pkg::C_IN_SLEEP]))
    && (flags_f[6] || !$past(cond.rise[cefl_pkg::C_BAT_OVP]))
    && (flags_f[5] || !$past(cond.rise[cefl_pkg::C_SYS_SHORT]))
    && (flags_f[4] || !$past(cond.rise[cefl_pkg::C_NODE_OV]))
    && (flags_f[4] || !$past(cond.rise[cefl_pkg::C_BOOST_REV]))
    && (flags_f[3] || !$past(cond.rise[cefl_pkg::C_TSHUT])))
    else $error("fault flag missed its second source");
  a_in_fault_set: assert property (
    cond.rise[cefl_pkg::C_IN_OVP] |=> flags_f[7])
    else $error("input fault flag missed");
  a_bat_fault_set: assert property (
    cond.rise[cefl_pkg::C_BAT_OCP] |=> flags_f[6])
    else $error("battery fault flag missed");
  a_sys_fault_set: assert property (
    cond.rise[cefl_pkg::C_SYS_OVP] |=> flags_f[5])
    else $error("system fault flag missed");
  a_boost_fault_set: assert property (
    cond.rise[cefl_pkg::C_NODE_UV] |=> flags_f[4])
    else $error("boost fault flag missed");
  a_tzone_change: assert property (
    zone != $past(zone) |=> flags_f[0])
    else $error("temperature zone change not flagged");
  a_reserved_zero: assert property (
    flags_a[7] == 1'b0 && flags_b[7:4] == 4'h0 && flags_b[2:1] == 2'h0
    && flags_f[2:1] == 2'h0)
    else $error("reserved flag bit nonzero");
  a_read_clears: assert property (
    rd_en_in && addr_in == cefl_pkg::ADDR_FLAGS_F && set_f == 8'h00
    |=> flags_f == 8'h00 && rd_data_out == $past(flags_f))
    else $error("read did not clear fault flags");
  a_set_beats_clear: assert property (
    rd_en_in && addr_in == cefl_pkg::ADDR_FLAGS_A && set_a[5] |=> flags_a[5])
    else $error("event lost during read");
  a_flag_holds: assert property (
    flags_b[0] && !(rd_en_in && addr_in == cefl_pkg::ADDR_FLAGS_B)
    |=> flags_b[0])
    else $error("flag dropped without a read");
  a_mask_gate: assert property (
    (set_all & ~mask_all) != 24'h000000 |=> !int_n_out ##1 int_n_out
      || (set_all & ~mask_all) != 24'h000000)
    else $error("unmasked event gave no single pulse");
  a_mask_block: assert property (
    (set_all & ~mask_all) == 24'h000000 |=> int_n_out)
    else $error("masked event pulsed interrupt");

  c_read_clear: cover property (
    flags_a != 8'h00 ##1 rd_en_in && addr_in == cefl_pkg::ADDR_FLAGS_A);
  c_set_in_read: cover property (
    rd_en_in && addr_in == cefl_pkg::ADDR_FLAGS_F && set_f != 8'h00);
  c_masked_event: cover property (set_all != 24'h0 && !int_n_out == 1'b0
    && (set_all & mask_all) != 24'h0);
  c_bias_fault: cover property (zone == cefl_pkg::TZ_BIAS_FAULT);

endmodule
`default_nettype wire

// file: hw/cefl_pkg.sv
// constants and types shared by the charger event flag latch block
// Functional notes
// - conversion-done flag, first register bit 6, set only in one-shot mode
// - thermal-regulation flag, bit 5, set on rising thermal regulation signal
// - minimum-system flag, bit 4, set on entry into or exit from regulation
// - input-current flag, bit 3, set on rise of current, pin or boost limit
// - input-voltage flag, bit 2, set on rise of input or boost voltage limit
// - safety-timer flag, bit 1, set on rising charge timer expiry
// - host-watchdog flag, bit 0, set on rising watchdog expiry
// - charge-phase flag, second register bit 3, set when charge status changes
// - input-source flag, second register bit 0, set when input status changes
// - input-fault flag, fault bit 7, set on input overvoltage or sleep entry
// - battery-fault flag, bit 6, set on battery overcurrent or overvoltage
// - system-fault flag, bit 5, set on system overvoltage or short
// - boost-fault flag, bit 4, set on reverse current or node under/overvoltage
// - thermal-shutdown flag, fault bit 3, set on rising shutdown signal
// - temperature-zone flag, fault bit 0, set when the zone code changes
// - flag registers read-only, reset 0x00, reserved bits always read zero
// - each flag has a mask bit, reset 0; unmasked events pulse interrupt
// - temperature zone is a 3-bit code, 0x7 being bias reference fault
package cefl_pkg;

  // register offsets
  localparam logic [7:0] ADDR_FLAGS_A   = 8'h20;
  localparam logic [7:0] ADDR_FLAGS_B   = 8'h21;
  localparam logic [7:0] ADDR_FLAGS_F   = 8'h22;
  localparam logic [7:0] ADDR_MASK_A    = 8'h23;
  localparam logic [7:0] ADDR_MASK_B    = 8'h24;
  localparam logic [7:0] ADDR_MASK_F    = 8'h25;

  // reset values and implemented-bit masks
  localparam logic [7:0] FLAG_RESET     = 8'h00;
  localparam logic [7:0] MASK_RESET     = 8'h00;
  localparam logic [7:0] FLAGS_A_USED   = 8'h7F;
  localparam logic [7:0] FLAGS_B_USED   = 8'h09;
  localparam logic [7:0] FLAGS_F_USED   = 8'hF9;
  localparam logic [7:0] MASK_A_USED    = 8'hFF;
  localparam logic [7:0] MASK_B_USED    = 8'h09;
  localparam logic [7:0] MASK_F_USED    = 8'hF9;

  // flag bit positions
  localparam int BIT_CONV_DONE   = 6;
  localparam int BIT_THERM_REG   = 5;
  localparam int BIT_MIN_SYS     = 4;
  localparam int BIT_IN_CUR      = 3;
  localparam int BIT_IN_VOLT     = 2;
  localparam int BIT_TIMER       = 1;
  localparam int BIT_WDOG        = 0;
  localparam int BIT_CHG_PHASE   = 3;
  localparam int BIT_IN_SRC      = 0;
  localparam int BIT_IN_FAULT    = 7;
  localparam int BIT_BAT_FAULT   = 6;
  localparam int BIT_SYS_FAULT   = 5;
  localparam int BIT_BOOST_FAULT = 4;
  localparam int BIT_TSHUT       = 3;
  localparam int BIT_TZONE       = 0;

  // positions of the condition signals in the sampled vector
  localparam int C_CONV_DONE   = 0;
  localparam int C_THERM_REG   = 1;
  localparam int C_MIN_SYS     = 2;
  localparam int C_IN_CUR      = 3;
  localparam int C_LIM_PIN     = 4;
  localparam int C_BOOST_CUR   = 5;
  localparam int C_IN_VOLT     = 6;
  localparam int C_BOOST_VOLT  = 7;
  localparam int C_TIMER       = 8;
  localparam int C_WDOG        = 9;
  localparam int C_IN_OVP      = 10;
  localparam int C_IN_SLEEP    = 11;
  localparam int C_BAT_OCP     = 12;
  localparam int C_BAT_OVP     = 13;
  localparam int C_SYS_OVP     = 14;
  localparam int C_SYS_SHORT   = 15;
  localparam int C_BOOST_REV   = 16;
  localparam int C_NODE_UV     = 17;
  localparam int C_NODE_OV     = 18;
  localparam int C_TSHUT       = 19;
  localparam int C_CHG_LSB     = 20;
  localparam int CHG_W         = 2;
  localparam int C_SRC_LSB     = 22;
  localparam int SRC_W         = 3;
  localparam int C_TZ_LSB      = 25;
  localparam int TZ_W          = 3;
  localparam int COND_W        = 28;

  // temperature zone codes
  typedef enum logic [2:0] {
    TZ_NORMAL     = 3'h0,
    TZ_COLD       = 3'h1,
    TZ_HOT        = 3'h2,
    TZ_COOL       = 3'h3,
    TZ_WARM       = 3'h4,
    TZ_PRECOOL    = 3'h5,
    TZ_PREWARM    = 3'h6,
    TZ_BIAS_FAULT = 3'h7
  } cefl_tzone_t;

endpackage
